// ---- rtl/dcf_filter.sv ----
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Two channels share one coefficient set.
// - Non-symmetric taps only, tap count 3 to 40 at generation.
// - Bits leave serially, channels alternating; one word pair takes 2N cycles.
// - All taps evaluated in parallel; 2N cycles regardless of taps.
// - Strobe high before an edge, while the ready flag is high, loads both words into the shifter.
// - Ready flag rises as the last bit is about to leave the shifter.
// - Both result buses update on one edge, held until the next.
// - Result-valid flag high for one cycle after new results are loaded.
// - Full precision through the tables and scaling accumulator.
// - Output width 2 to 31 bits, chosen at generation.
// - Input width 4 to 16, or 4 to 8 with reversed channel B.
// - Coefficient width 4 to 24; sum tables widen for growth.
// - Coefficients preformatted into tables addressed by serial bits.
// - Trimming replaces constant tables with constant logic.
// - Option: channel B uses the coefficients in reversed order.
// - Serial or parallel input, per channel when B is reversed.
// - Oldest words leave on cascade outputs for chaining filters.
// - Inputs are two's complement; results come from output registers.
module dcf_filter (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [dcf_pkg::ADDR_W-1:0]       paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic                             new_word_strobe,
  input  wire logic [dcf_pkg::DATA_W-1:0]       chan_a_data_in,
  input  wire logic [dcf_pkg::DATA_W-1:0]       chan_b_data_in,
  input  wire logic                             chan_a_serial_in,
  input  wire logic                             chan_b_serial_in,
  output logic                                  input_ready_flag,
  output logic                                  result_valid,
  output logic      [dcf_pkg::OUT_W-1:0]        chan_a_filter_out,
  output logic      [dcf_pkg::OUT_W-1:0]        chan_b_filter_out,
  output logic      [dcf_pkg::DATA_W-1:0]       chan_a_cascade_out,
  output logic      [dcf_pkg::DATA_W-1:0]       chan_b_cascade_out
);

  localparam int DW = dcf_pkg::DATA_W;
  localparam int FW = dcf_pkg::FULL_W;
  localparam int OW = dcf_pkg::OUT_W;
  localparam int CW = dcf_pkg::CNT_W;

  // One table entry: sum of the coefficients picked by four bits
  function automatic logic signed [FW-1:0] rom_entry(input int grp,
                                                     input logic [3:0] addr,
                                                     input logic rev);
    logic signed [FW-1:0] sum;
    int                   tap;
    int                   idx;
    sum = '0;
    for (int k = 0; k < 4; k++) begin
      tap = grp * 4 + k;
      idx = rev ? (dcf_pkg::TAPS - 1 - tap) : tap;
      if (tap < dcf_pkg::TAPS && addr[k]) begin
        sum = sum + FW'(dcf_pkg::COEF[idx]);
      end
    end
    return sum;
  endfunction

  // Table is constant logic when every entry equals the first
  function automatic logic rom_is_const(input int grp, input logic rev);
    logic same;
    same = 1'b1;
    for (int a = 1; a < 16; a++) begin
      if (rom_entry(grp, 4'(a), rev) != rom_entry(grp, 4'h0, rev)) begin
        same = 1'b0;
      end
    end
    return same;
  endfunction

  // Table lookup with optional trimming
  function automatic logic signed [FW-1:0] rom_read(input int grp,
                                                    input logic [3:0] addr,
                                                    input logic rev);
    logic signed [FW-1:0] val;
    val = rom_entry(grp, addr, rev);
    if (dcf_pkg::TRIM_ROMS && rom_is_const(grp, rev)) begin
      val = rom_entry(grp, 4'h0, rev);
    end
    return val;
  endfunction

  dcf_pkg::dcf_state_t           state_ff;
  logic [CW-1:0]                 slot_ff;
  logic signed [DW-1:0]          line_a_ff [dcf_pkg::TAPS];
  logic signed [DW-1:0]          line_b_ff [dcf_pkg::TAPS];
  logic [DW-1:0]                 ser_a_ff;
  logic [DW-1:0]                 ser_b_ff;
  logic signed [FW-1:0]          acc_a_ff;
  logic signed [FW-1:0]          acc_b_ff;
  logic                          rfd_ff;
  logic                          rdy_ff;
  logic [OW-1:0]                 out_a_ff;
  logic [OW-1:0]                 out_b_ff;
  logic [DW-1:0]                 casc_a_ff;
  logic [DW-1:0]                 casc_b_ff;
  logic                          ctrl_en_ff;
  logic                          clr_ff;
  logic [dcf_pkg::PAIRS_W-1:0]   pairs_ff;
  logic [31:0]                   prdata_ff;
  logic                          pready_ff;
  logic                          pslverr_ff;

  logic                          load;
  logic                          last_slot;
  logic                          chan_b_slot;
  logic [CW-2:0]                 bit_idx;
  logic signed [FW-1:0]          da_sum;
  logic signed [FW-1:0]          term;
  logic signed [FW-1:0]          nxt_acc_a;
  logic signed [FW-1:0]          nxt_acc_b;
  logic [DW-1:0]                 word_a;
  logic [DW-1:0]                 word_b;
  logic                          apb_done;
  logic                          apb_wr;
  logic [31:0]                   rd_mux;
  logic                          rd_err;

  assign load        = new_word_strobe & rfd_ff;
  assign last_slot   = (slot_ff == CW'(dcf_pkg::SLOTS - 1));
  assign chan_b_slot = slot_ff[0];
  assign bit_idx     = slot_ff[CW-1:1];
  assign word_a      = dcf_pkg::A_SERIAL ? ser_a_ff : chan_a_data_in;
  assign word_b      = dcf_pkg::B_SERIAL ? ser_b_ff : chan_b_data_in;

  // Shared tables, addressed by one bit of every tap at once
  always_comb begin
    logic [3:0] addr;
    addr   = '0;
    da_sum = '0;
    for (int g = 0; g < dcf_pkg::GROUPS; g++) begin
      for (int k = 0; k < 4; k++) begin
        if (g * 4 + k < dcf_pkg::TAPS) begin
          addr[k] = chan_b_slot ? line_b_ff[g * 4 + k][bit_idx]
                                : line_a_ff[g * 4 + k][bit_idx];
        end else begin
          addr[k] = 1'b0;
        end
      end
      da_sum = da_sum + rom_read(g, addr, chan_b_slot & dcf_pkg::REVERSE_B);
    end
  end

  // Scaling accumulator, sign bit weight negative
  always_comb begin
    term = da_sum <<< bit_idx;
    if (bit_idx == (CW-1)'(DW - 1)) begin
      term = -term;
    end
    nxt_acc_a = (slot_ff == '0 ? '0 : acc_a_ff) + term;
    nxt_acc_b = (slot_ff == CW'(1) ? '0 : acc_b_ff) + term;
  end

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= dcf_pkg::DCF_IDLE;
      slot_ff  <= '0;
    end else begin
      case (state_ff)
        dcf_pkg::DCF_IDLE: begin
          if (load) begin
            state_ff <= dcf_pkg::DCF_RUN;
            slot_ff  <= '0;
          end
        end
        dcf_pkg::DCF_RUN: begin
          if (last_slot) begin
            slot_ff  <= '0;
            state_ff <= load ? dcf_pkg::DCF_RUN : dcf_pkg::DCF_IDLE;
          end else begin
            slot_ff  <= slot_ff + CW'(1);
          end
        end
        default: begin
          state_ff <= dcf_pkg::DCF_IDLE;
          slot_ff  <= '0;
        end
      endcase
    end
  end

  // Ready flag: when enabled, high in the last slot and while idle; low while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rfd_ff <= dcf_pkg::CTRL_EN_RST;
    end else if (!ctrl_en_ff) begin
      rfd_ff <= 1'b0;
    end else if (state_ff == dcf_pkg::DCF_RUN) begin
      rfd_ff <= (slot_ff == CW'(dcf_pkg::SLOTS - 2)) || (last_slot && !load);
    end else begin
      rfd_ff <= !load;
    end
  end

  // Delay lines and cascade outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int t = 0; t < dcf_pkg::TAPS; t++) begin
        line_a_ff[t] <= '0;
        line_b_ff[t] <= '0;
      end
      casc_a_ff <= '0;
      casc_b_ff <= '0;
    end else if (clr_ff) begin
      for (int t = 0; t < dcf_pkg::TAPS; t++) begin
        line_a_ff[t] <= '0;
        line_b_ff[t] <= '0;
      end
      casc_a_ff <= '0;
      casc_b_ff <= '0;
    end else if (load) begin
      line_a_ff[0] <= word_a;
      line_b_ff[0] <= word_b;
      for (int t = 1; t < dcf_pkg::TAPS; t++) begin
        line_a_ff[t] <= line_a_ff[t-1];
        line_b_ff[t] <= line_b_ff[t-1];
      end
      casc_a_ff <= line_a_ff[dcf_pkg::TAPS-1];
      casc_b_ff <= line_b_ff[dcf_pkg::TAPS-1];
    end
  end

  // Serial input assembly, LSB first in own channel slots
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_a_ff <= '0;
      ser_b_ff <= '0;
    end else if (state_ff == dcf_pkg::DCF_RUN) begin
      if (!chan_b_slot) begin
        ser_a_ff <= {chan_a_serial_in, ser_a_ff[DW-1:1]};
      end else begin
        ser_b_ff <= {chan_b_serial_in, ser_b_ff[DW-1:1]};
      end
    end
  end

  // Accumulators
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_a_ff <= '0;
      acc_b_ff <= '0;
    end else if (state_ff == dcf_pkg::DCF_RUN) begin
      if (!chan_b_slot) begin
        acc_a_ff <= nxt_acc_a;
      end else begin
        acc_b_ff <= nxt_acc_b;
      end
    end
  end

  // Output registers, both channels on one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a_ff <= '0;
      out_b_ff <= '0;
      rdy_ff   <= 1'b0;
      pairs_ff <= '0;
    end else begin
      rdy_ff <= (state_ff == dcf_pkg::DCF_RUN) && last_slot;
      if ((state_ff == dcf_pkg::DCF_RUN) && last_slot) begin
        out_a_ff <= acc_a_ff[FW-1 -: OW];
        out_b_ff <= nxt_acc_b[FW-1 -: OW];
        pairs_ff <= pairs_ff + dcf_pkg::PAIRS_W'(1);
      end
    end
  end

  // APB slave: one wait state, answer on second access cycle
  assign apb_done = psel & penable & pready_ff;
  assign apb_wr   = apb_done & pwrite;

  always_comb begin
    rd_mux = '0;
    rd_err = 1'b0;
    case (paddr)
      dcf_pkg::OFS_CTRL:   rd_mux[dcf_pkg::CTRL_EN_BIT] = ctrl_en_ff;
      dcf_pkg::OFS_STATUS: begin
        rd_mux[dcf_pkg::STAT_RFD_BIT]  = rfd_ff;
        rd_mux[dcf_pkg::STAT_RDY_BIT]  = rdy_ff;
        rd_mux[dcf_pkg::STAT_BUSY_BIT] = (state_ff == dcf_pkg::DCF_RUN);
      end
      dcf_pkg::OFS_RES_A:  rd_mux[OW-1:0] = out_a_ff;
      dcf_pkg::OFS_RES_B:  rd_mux[OW-1:0] = out_b_ff;
      dcf_pkg::OFS_PAIRS:  rd_mux[dcf_pkg::PAIRS_W-1:0] = pairs_ff;
      default:             rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= '0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel & penable & !pready_ff;
      prdata_ff  <= (psel & penable & !pready_ff & !pwrite) ? rd_mux : '0;
      pslverr_ff <= psel & penable & !pready_ff & rd_err;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_ff <= dcf_pkg::CTRL_EN_RST;
      clr_ff     <= 1'b0;
    end else begin
      clr_ff <= apb_wr && (paddr == dcf_pkg::OFS_CTRL) && pwdata[dcf_pkg::CTRL_CLR_BIT];
      if (apb_wr && (paddr == dcf_pkg::OFS_CTRL)) begin
        ctrl_en_ff <= pwdata[dcf_pkg::CTRL_EN_BIT];
      end
    end
  end

  assign prdata             = prdata_ff;
  assign pready             = pready_ff;
  assign pslverr            = pslverr_ff;
  assign input_ready_flag   = rfd_ff;
  assign result_valid       = rdy_ff;
  assign chan_a_filter_out  = out_a_ff;
  assign chan_b_filter_out  = out_b_ff;
  assign chan_a_cascade_out = casc_a_ff;
  assign chan_b_cascade_out = casc_b_ff;

endmodule // dcf_filter

`default_nettype wire

// ---- shared/dcf_pkg.sv ----
package dcf_pkg;

  // Generation choices
  localparam int DATA_W    = 12;
  localparam int COEF_W    = 14;
  localparam int TAPS      = 8;
  localparam int GROUPS    = (TAPS + 3) / 4;
  localparam int FULL_W    = COEF_W + $clog2(TAPS) + DATA_W;
  localparam int OUT_W     = 16;
  localparam int SLOTS     = 2 * DATA_W;
  localparam int CNT_W     = $clog2(SLOTS);
  localparam bit TRIM_ROMS = 1'b1;
  localparam bit REVERSE_B = 1'b0;
  localparam bit A_SERIAL  = 1'b0;
  localparam bit B_SERIAL  = 1'b0;

  // Coefficient set, tap 0 first
  localparam logic signed [COEF_W-1:0] COEF [TAPS] = '{
    14'sh0010, 14'sh0040, 14'sh0100, 14'sh01F0,
    14'sh01F0, 14'sh0100, 14'sh0040, 14'sh0010
  };

  // Register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RES_A  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RES_B  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PAIRS  = 8'h10;

  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_CLR_BIT   = 1;
  localparam int STAT_RFD_BIT   = 0;
  localparam int STAT_RDY_BIT   = 1;
  localparam int STAT_BUSY_BIT  = 2;
  localparam logic CTRL_EN_RST  = 1'b1;
  localparam int PAIRS_W        = 16;

  typedef enum logic [0:0] {
    DCF_IDLE = 1'b0,
    DCF_RUN  = 1'b1
  } dcf_state_t;

endpackage

// ---- verif/dcf_filter_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module dcf_filter_props (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic [31:0]               prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic                      new_word_strobe,
  input wire logic                      input_ready_flag,
  input wire logic                      result_valid,
  input wire logic [dcf_pkg::OUT_W-1:0] chan_a_filter_out,
  input wire logic [dcf_pkg::OUT_W-1:0] chan_b_filter_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ld;
  assign ld = new_word_strobe && input_ready_flag;

  chk_load_drops_ready:
    assert property (ld |=> !input_ready_flag) else $error("ready stayed high after load");
  chk_ready_rise:
    assert property (ld |-> ##23 !input_ready_flag ##1 input_ready_flag)
    else $error("ready flag rise off slot");
  chk_pair_period:
    assert property (ld |-> ##25 result_valid) else $error("result not 25 cycles after load");
  chk_valid_cause:
    assert property (result_valid |-> $past(ld, 25)) else $error("result without load");
  chk_valid_pulse:
    assert property (result_valid |=> !result_valid) else $error("result valid too long");
  chk_outs_hold:
    assert property (!result_valid |-> $stable(chan_a_filter_out) && $stable(chan_b_filter_out))
    else $error("result bus moved without valid");
  chk_pready_slot:
    assert property (psel && !penable |-> ##1 !pready ##1 pready) else $error("pready slot");
  chk_pready_pulse:
    assert property (pready |=> !pready) else $error("pready too long");
  chk_bus_idle:
    assert property (!pready |-> !pslverr && prdata == '0) else $error("apb outputs not idle");
endmodule // dcf_filter_props

bind dcf_filter dcf_filter_props dcf_filter_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .new_word_strobe(new_word_strobe),
  .input_ready_flag(input_ready_flag), .result_valid(result_valid),
  .chan_a_filter_out(chan_a_filter_out), .chan_b_filter_out(chan_b_filter_out));
`default_nettype wire

// ---- verif/dcf_src_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module dcf_src_model (
  input  wire logic                        pclk,
  input  wire logic                        input_ready_flag,
  output logic                             new_word_strobe,
  output logic [dcf_pkg::DATA_W-1:0]       chan_a_data_in,
  output logic [dcf_pkg::DATA_W-1:0]       chan_b_data_in
);
  logic [2*dcf_pkg::DATA_W-1:0] q[$];
  int   gap = 0;
  int   idle = 0;
  logic rdy_n = 1'b1;
  initial begin
    new_word_strobe = 1'b0;
    chan_a_data_in = '0;
    chan_b_data_in = '0;
  end
  always @(negedge pclk) rdy_n <= input_ready_flag;
  always @(posedge pclk) begin
    if (new_word_strobe && rdy_n) begin
      new_word_strobe <= 1'b0;
      chan_a_data_in <= ~chan_a_data_in;
      chan_b_data_in <= ~chan_b_data_in;
      idle <= 0;
    end else if (rdy_n && q.size() > 0 && idle >= gap) begin
      {chan_a_data_in, chan_b_data_in} <= q.pop_front();
      new_word_strobe <= 1'b1;
    end else begin
      idle <= idle + 1;
    end
  end
endmodule // dcf_src_model
`default_nettype wire

// ---- verif/dcf_filter_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module dcf_filter_test;
  logic                         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [dcf_pkg::ADDR_W-1:0]   paddr;
  logic [31:0]                  pwdata, prdata, rd;
  logic                         strobe, rdy, valid, er;
  logic [dcf_pkg::DATA_W-1:0]   a_in, b_in;
  logic [dcf_pkg::DATA_W-1:0]   ca_out, cb_out, ca_exp, cb_exp;
  logic [dcf_pkg::OUT_W-1:0]    a_out, b_out, ea, eb, last_a, last_b;
  logic [2*dcf_pkg::OUT_W-1:0]  exp_q[$];
  logic signed [dcf_pkg::DATA_W-1:0] ha[dcf_pkg::TAPS], hb[dcf_pkg::TAPS];
  logic [15:0]                  lf = 16'h0046;
  int                           bad_count = 0, n_tests = 0, pairs = 0;

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  dcf_filter dcf_filter_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .new_word_strobe(strobe), .chan_a_data_in(a_in), .chan_b_data_in(b_in),
    .chan_a_serial_in(1'b0), .chan_b_serial_in(1'b0), .input_ready_flag(rdy),
    .result_valid(valid), .chan_a_filter_out(a_out), .chan_b_filter_out(b_out),
    .chan_a_cascade_out(ca_out), .chan_b_cascade_out(cb_out));
  dcf_src_model dcf_src_model_i (.pclk(pclk), .input_ready_flag(rdy),
    .new_word_strobe(strobe), .chan_a_data_in(a_in), .chan_b_data_in(b_in));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task give_verdict;
    if (bad_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [dcf_pkg::ADDR_W-1:0] ad, input logic [31:0] wd);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin bad_count++; give_verdict(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task send(input logic [dcf_pkg::DATA_W-1:0] a, input logic [dcf_pkg::DATA_W-1:0] b);
    logic signed [dcf_pkg::FULL_W-1:0] fa, fb;
    fa = '0;
    fb = '0;
    ca_exp = ha[dcf_pkg::TAPS-1];
    cb_exp = hb[dcf_pkg::TAPS-1];
    for (int k = dcf_pkg::TAPS - 1; k > 0; k--) begin ha[k] = ha[k-1]; hb[k] = hb[k-1]; end
    ha[0] = a;
    hb[0] = b;
    for (int k = 0; k < dcf_pkg::TAPS; k++) begin
      fa += dcf_pkg::COEF[k] * ha[k];
      fb += dcf_pkg::COEF[k] * hb[k];
    end
    exp_q.push_back({fa[dcf_pkg::FULL_W-1 -: dcf_pkg::OUT_W], fb[dcf_pkg::FULL_W-1 -: dcf_pkg::OUT_W]});
    last_a = fa[dcf_pkg::FULL_W-1 -: dcf_pkg::OUT_W];
    last_b = fb[dcf_pkg::FULL_W-1 -: dcf_pkg::OUT_W];
    dcf_src_model_i.q.push_back({a, b});
    pairs++;
  endtask

  task drain;
    int i;
    for (i = 0; i < 3000 && exp_q.size() > 0; i++) @(negedge pclk);
    if (exp_q.size() > 0) begin bad_count++; give_verdict(); end
  endtask

  always @(negedge pclk) begin
    if (presetn && valid === 1'b1) begin
      if (exp_q.size() == 0) chk("spare result", 32'h0, 32'h1);
      else begin
        {ea, eb} = exp_q.pop_front();
        chk("chan_a_filter_out", {16'h0000, ea}, {16'h0000, a_out});
        chk("chan_b_filter_out", {16'h0000, eb}, {16'h0000, b_out});
      end
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end

  initial begin
    for (int k = 0; k < dcf_pkg::TAPS; k++) begin ha[k] = '0; hb[k] = '0; end
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("ready after reset", 32'h1, {31'h0, rdy});
    chk("valid after reset", 32'h0, {31'h0, valid});
    apb(1'b1, dcf_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, dcf_pkg::OFS_STATUS, 32'h0);
    chk("status", 32'h1, rd);
    apb(1'b0, dcf_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, dcf_pkg::OFS_CTRL, 32'h0);
    repeat (2) @(negedge pclk);
    chk("ready when off", 32'h0, {31'h0, rdy});
    apb(1'b1, dcf_pkg::OFS_CTRL, 32'h1);
    send(12'h800, 12'h7FF);
    send(12'h7FF, 12'h800);
    for (int j = 0; j < 30; j++) begin
      lf = lfsr(lf);
      send(lf[11:0], lf[15:4]);
    end
    drain();
    dcf_src_model_i.gap = 7;
    apb(1'b1, dcf_pkg::OFS_CTRL, 32'h3);
    repeat (2) @(posedge pclk);
    for (int k = 0; k < dcf_pkg::TAPS; k++) begin ha[k] = '0; hb[k] = '0; end
    for (int j = 0; j < 9; j++) begin
      lf = lfsr(lf);
      send(lf[15:4], lf[11:0]);
    end
    drain();
    apb(1'b0, dcf_pkg::OFS_PAIRS, 32'h0);
    chk("pair count", pairs, rd);
    apb(1'b0, dcf_pkg::OFS_RES_A, 32'h0);
    chk("result a reg", {16'h0000, last_a}, rd);
    apb(1'b0, dcf_pkg::OFS_RES_B, 32'h0);
    chk("result b reg", {16'h0000, last_b}, rd);
    chk("chan_a_cascade_out", {20'h00000, ca_exp}, {20'h00000, ca_out});
    chk("chan_b_cascade_out", {20'h00000, cb_exp}, {20'h00000, cb_out});
    give_verdict();
  end
endmodule // dcf_filter_test
`default_nettype wire
